// [pkg/ubf_pkg.sv]
`default_nettype none
package ubf_pkg;

  // ************************************************************
  // Register map (byte addresses) and field positions
  // ************************************************************
  localparam logic [7:0] UBF_OFF_BAUD_HI = 8'h00;
  localparam logic [7:0] UBF_OFF_BAUD_LO = 8'h04;
  localparam logic [7:0] UBF_OFF_CTRL1   = 8'h08;
  localparam logic [7:0] UBF_OFF_CTRL2   = 8'h0c;
  localparam logic [7:0] UBF_OFF_STAT1   = 8'h10;
  localparam logic [7:0] UBF_OFF_STAT2   = 8'h14;
  localparam logic [7:0] UBF_OFF_CTRL3   = 8'h18;
  localparam logic [7:0] UBF_OFF_DATA    = 8'h1c;

  localparam int UBF_HI_BRK_IE  = 7;
  localparam int UBF_HI_EDGE_IE = 6;
  localparam int UBF_C1_LOOP    = 7;
  localparam int UBF_C1_SWAI    = 6;
  localparam int UBF_C1_RECEIVER_SOURCE_SELECT    = 5;
  localparam int UBF_C1_NINE    = 4;
  localparam int UBF_C1_WAKE    = 3;
  localparam int UBF_C1_ILT     = 2;
  localparam int UBF_C1_PE      = 1;
  localparam int UBF_C1_PT      = 0;
  localparam int UBF_C2_TX_ON   = 3;
  localparam int UBF_C2_RX_ON   = 2;
  localparam int UBF_C2_RWU     = 1;
  localparam int UBF_C3_RX8     = 7;
  localparam int UBF_C3_TX8     = 6;
  localparam int UBF_C3_DIR     = 5;
  localparam int UBF_ST_BRK     = 7;
  localparam int UBF_ST_EDGE    = 6;
  localparam int UBF_ST_IDLE    = 4;
  localparam int UBF_ST_OVR     = 3;
  localparam int UBF_ST_FE      = 1;
  localparam int UBF_ST_PE      = 0;

  localparam logic [7:0] UBF_HI_MASK = 8'hdf;
  localparam logic [7:0] UBF_C2_MASK = 8'h0e;
  localparam logic [7:0] UBF_C3_MASK = 8'h60;

  // ************************************************************
  // Reset values and timing counts
  // ************************************************************
  localparam logic [7:0] UBF_RST_BAUD_HI = 8'h00;
  localparam logic [7:0] UBF_RST_BAUD_LO = 8'h04;
  localparam logic [7:0] UBF_RST_CTRL    = 8'h00;
  localparam logic       UBF_LINE_IDLE   = 1'b1;
  localparam logic [3:0] UBF_SUB_LAST    = 4'hf;
  localparam logic [3:0] UBF_SUB_MID     = 4'h7;
  localparam logic [3:0] UBF_FRAME_8     = 4'ha;
  localparam logic [3:0] UBF_FRAME_9     = 4'hb;
  localparam logic [3:0] UBF_DATA_8      = 4'h8;
  localparam logic [3:0] UBF_DATA_9      = 4'h9;
  localparam logic [1:0] UBF_RESP_OKAY   = 2'h0;
  localparam logic [1:0] UBF_RESP_SLVERR = 2'h2;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } ubf_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ubf_axi_rsp_t;

  typedef enum logic {UBF_TX_IDLE, UBF_TX_SHIFT} ubf_tx_state_t;
  typedef enum logic [1:0] {UBF_RX_IDLE, UBF_RX_START, UBF_RX_DATA, UBF_RX_STOP} ubf_rx_state_t;

  function automatic logic ubf_mapped(input logic [7:0] addr);
    return (addr[1:0] == 2'h0) && (addr[7:5] == 3'h0);
  endfunction

  // Parity bit that makes the character even, or odd when odd_sel is set.
  function automatic logic ubf_parity(input logic [8:0] d, input logic nine, input logic odd_sel);
    return (nine ? (^d[7:0]) : (^d[6:0])) ^ odd_sel;
  endfunction

endpackage
`default_nettype wire

// [rtl/ubf_sync3.sv]
`timescale 1ns/1ps
`default_nettype none
module ubf_sync3
  import ubf_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic din,
  output var  logic dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic dout_next;

  // A change is accepted only once the second and third stages agree.
  always_comb begin
    dout_next = (s2_reg == s3_reg) ? s3_reg : dout;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= UBF_LINE_IDLE;
      s2_reg <= UBF_LINE_IDLE;
      s3_reg <= UBF_LINE_IDLE;
      dout   <= UBF_LINE_IDLE;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      dout   <= dout_next;
    end
  end
endmodule // ubf_sync3
`default_nettype wire

// [rtl/ubf_baud_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module ubf_baud_gen
  import ubf_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        enable,
  input  wire logic        hold,
  input  wire logic [12:0] divisor,
  output var  logic        tick
);
  logic [12:0] cnt_reg;
  logic [12:0] cnt_next;
  logic        tick_next;

  always_comb begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!enable || divisor == 13'h0000) begin
      cnt_next = 13'h0000;
    end else if (!hold) begin
      // divide by divisor
      // The compare is >= so that a smaller new divisor cannot strand the count.
      if (cnt_reg >= divisor - 13'h0001) begin
        cnt_next  = 13'h0000;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 13'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 13'h0000;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick    <= tick_next;
    end
  end
endmodule // ubf_baud_gen
`default_nettype wire

// [rtl/ubf_uart_cfg_top.sv]
// Function
// - High-half writes only buffer; working divisor updates on low-half write.
// - Divisor zero disables the baud generator entirely.
// - Bit rate is bus clock over sixteen times the divisor.
// - Low half resets non-zero; generator idles until tx or rx enabled.
// - Break interrupt requested while break flag set and its enable set.
// - Edge interrupt requested while rx edge flag set and its enable set.
// - Loopback feeds transmitter into receiver; receive pin unused.
// - Stop-in-wait freezes the serial unit during processor wait.
// - Source select matters only in loopback; zero means internal loop.
// - Loopback with source one is single-wire on the transmit pin.
// - Eight or nine data bits, least significant first, both directions.
// - Wake method selects idle-line or address-mark wakeup.
// - Idle needs 10 or 11 high bit times; count from start or stop.
// - Parity enable generates and checks parity in the top data bit.
// - Parity kind zero even, one odd, over whole character.
// - Eight byte-wide registers for baud, options, status and data.
// - Transmitter starts frames only while its enable is one.
`timescale 1ns/1ps
`default_nettype none
module ubf_uart_cfg_top
  import ubf_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire ubf_axi_req_t axi_req,
  output var  ubf_axi_rsp_t axi_rsp,
  input  wire logic         rxd_pin_in,
  input  wire logic         txd_pin_in,
  output var  logic         txd_pin_out,
  output var  logic         txd_pin_oe,
  input  wire logic         cpu_wait,
  output var  logic         irq_request
);
  // ************************************************************
  // State
  // ************************************************************
  logic [7:0]    hi_reg, hi_next, lo_reg, lo_next;
  logic [7:0]    c1_reg, c1_next, c2_reg, c2_next, c3_reg, c3_next;
  logic [4:0]    work_hi_reg, work_hi_next;
  logic          baud_active_reg, baud_active_next;
  logic [8:0]    tx_buf_reg, tx_buf_next, rx_data_reg, rx_data_next;
  logic          tx_full_reg, tx_full_next, rx_full_reg, rx_full_next;
  logic [7:0]    flag_reg, flag_next;
  logic          irq_next;
  logic          aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [7:0]    aw_addr_reg, aw_addr_next, w_data_reg, w_data_next;
  logic          w_strb_reg, w_strb_next;
  ubf_axi_rsp_t  rsp_next;

  ubf_tx_state_t tx_state_reg, tx_state_next;
  logic [10:0]   tx_sh_reg, tx_sh_next;
  logic [3:0]    tx_left_reg, tx_left_next, tx_sub_reg, tx_sub_next;
  logic          tx_line_reg, tx_line_next, tx_oe_next;

  ubf_rx_state_t rx_state_reg, rx_state_next;
  logic [3:0]    rx_sub_reg, rx_sub_next, rx_cnt_reg, rx_cnt_next;
  logic [8:0]    rx_sh_reg, rx_sh_next;
  logic [3:0]    idle_bits_reg, idle_bits_next, idle_sub_reg, idle_sub_next;
  logic          idle_armed_reg, idle_armed_next, rx_prev_reg, rx_prev_next;

  logic          rxd_sync, txd_sync, tick, frz, rx_line, tx_load;
  logic          rx_done, rx_fe, rx_pe, rx_brk, rx_idle_hit, rx_edge_hit;
  logic [8:0]    rx_word;
  logic          do_wr, wr_en, deliver, msb, rd_clr;
  logic [7:0]    clr, set, rd_byte;

  // ************************************************************
  // Pin synchronisers and baud generator
  // ************************************************************
  ubf_sync3 u_rxd_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (rxd_pin_in),
    .dout    (rxd_sync)
  );
  ubf_sync3 u_txd_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (txd_pin_in),
    .dout    (txd_sync)
  );

  assign frz = c1_reg[UBF_C1_SWAI] & cpu_wait;

  ubf_baud_gen u_baud (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (baud_active_reg),
    .hold    (frz),
    .divisor ({work_hi_reg, lo_reg}),
    .tick    (tick)
  );

  assign rx_line = !c1_reg[UBF_C1_LOOP] ? rxd_sync :
                   (c1_reg[UBF_C1_RECEIVER_SOURCE_SELECT] ? txd_sync : tx_line_reg);

  assign tx_load = (tx_state_reg == UBF_TX_IDLE) && tx_full_reg && c2_reg[UBF_C2_TX_ON];

  // ************************************************************
  // Register file and bus slave
  // ************************************************************
  always_comb begin
    hi_next = hi_reg;  lo_next = lo_reg;  c1_next = c1_reg;
    c2_next = c2_reg;  c3_next = c3_reg;  work_hi_next = work_hi_reg;
    baud_active_next = baud_active_reg;
    tx_buf_next = tx_buf_reg;  rx_data_next = rx_data_reg;
    aw_full_next = aw_full_reg;  aw_addr_next = aw_addr_reg;
    w_full_next = w_full_reg;  w_data_next = w_data_reg;  w_strb_next = w_strb_reg;
    rsp_next = axi_rsp;
    clr = 8'h00;  set = 8'h00;  rd_clr = 1'b0;  deliver = 1'b0;
    rd_byte = 8'h00;
    if (axi_req.awvalid && axi_rsp.awready) begin
      aw_full_next = 1'b1;
      aw_addr_next = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      w_full_next = 1'b1;
      w_data_next = axi_req.wdata[7:0];
      w_strb_next = axi_req.wstrb[0];
    end
    if (axi_rsp.bvalid && axi_req.bready) rsp_next.bvalid = 1'b0;
    do_wr = aw_full_reg && w_full_reg && !axi_rsp.bvalid;
    wr_en = do_wr && w_strb_reg && ubf_mapped(aw_addr_reg);
    if (do_wr) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      rsp_next.bvalid = 1'b1;
      rsp_next.bresp = ubf_mapped(aw_addr_reg) ? UBF_RESP_OKAY : UBF_RESP_SLVERR;
    end
    rsp_next.awready = !aw_full_next;
    rsp_next.wready = !w_full_next;
    msb = c1_reg[UBF_C1_NINE] ? rx_word[8] : rx_word[7];
    if (rx_done) begin
      if (!c2_reg[UBF_C2_RWU]) begin
        deliver = 1'b1;
      end else if (c1_reg[UBF_C1_WAKE] && msb) begin
        deliver = 1'b1;
        c2_next[UBF_C2_RWU] = 1'b0;
      end
    end
    if (rx_idle_hit && c2_reg[UBF_C2_RWU] && !c1_reg[UBF_C1_WAKE]) c2_next[UBF_C2_RWU] = 1'b0;
    if (wr_en) begin
      case (aw_addr_reg)
        UBF_OFF_BAUD_HI: hi_next = w_data_reg & UBF_HI_MASK;
        UBF_OFF_BAUD_LO: begin
          lo_next = w_data_reg;
          work_hi_next = hi_reg[4:0];
        end
        UBF_OFF_CTRL1: c1_next = w_data_reg;
        UBF_OFF_CTRL2: begin
          c2_next = w_data_reg & UBF_C2_MASK;
          if (w_data_reg[UBF_C2_TX_ON] || w_data_reg[UBF_C2_RX_ON]) baud_active_next = 1'b1;
        end
        UBF_OFF_STAT2: clr = w_data_reg;
        UBF_OFF_CTRL3: c3_next = w_data_reg & UBF_C3_MASK;
        UBF_OFF_DATA: tx_buf_next = {c3_reg[UBF_C3_TX8], w_data_reg};
        default: ;
      endcase
    end
    if (axi_rsp.rvalid && axi_req.rready) rsp_next.rvalid = 1'b0;
    if (axi_req.arvalid && axi_rsp.arready) begin
      case (axi_req.araddr)
        UBF_OFF_BAUD_HI: rd_byte = hi_reg;
        UBF_OFF_BAUD_LO: rd_byte = lo_reg;
        UBF_OFF_CTRL1: rd_byte = c1_reg;
        UBF_OFF_CTRL2: rd_byte = c2_reg;
        UBF_OFF_STAT1: rd_byte = {!tx_full_reg, !tx_full_reg && tx_state_reg == UBF_TX_IDLE,
                                  rx_full_reg, flag_reg[4:0]};
        UBF_OFF_STAT2: rd_byte = flag_reg;
        UBF_OFF_CTRL3: rd_byte = {rx_data_reg[8], c3_reg[6:0]};
        UBF_OFF_DATA: begin
          rd_byte = rx_data_reg[7:0];
          rd_clr = 1'b1;
        end
        default: rd_byte = 8'h00;
      endcase
      rsp_next.rvalid = 1'b1;
      rsp_next.rdata = {24'h000000, rd_byte};
      rsp_next.rresp = ubf_mapped(axi_req.araddr) ? UBF_RESP_OKAY : UBF_RESP_SLVERR;
    end
    rsp_next.arready = !rsp_next.rvalid;
    // An overrun keeps the unread character and drops the new one.
    if (deliver) begin
      if (rx_full_reg && !rd_clr) set[UBF_ST_OVR] = 1'b1;
      else rx_data_next = rx_word;
      set[UBF_ST_FE] = rx_fe;
      set[UBF_ST_PE] = rx_pe;
    end
    set[UBF_ST_BRK] = rx_brk;
    set[UBF_ST_EDGE] = rx_edge_hit;
    set[UBF_ST_IDLE] = rx_idle_hit && !c2_reg[UBF_C2_RWU];
    // A hardware set in the same cycle as a clear is kept.
    flag_next = (flag_reg & ~clr) | set;
    rx_full_next = (rx_full_reg & ~rd_clr) | deliver;
    tx_full_next = (tx_full_reg & ~tx_load) | (wr_en && aw_addr_reg == UBF_OFF_DATA);
    irq_next = (flag_next[UBF_ST_BRK] & hi_reg[UBF_HI_BRK_IE]) |
               (flag_next[UBF_ST_EDGE] & hi_reg[UBF_HI_EDGE_IE]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_reg <= UBF_RST_BAUD_HI;  lo_reg <= UBF_RST_BAUD_LO;
      c1_reg <= UBF_RST_CTRL;  c2_reg <= UBF_RST_CTRL;  c3_reg <= UBF_RST_CTRL;
      work_hi_reg <= 5'h00;  baud_active_reg <= 1'b0;
      tx_buf_reg <= 9'h000;  rx_data_reg <= 9'h000;
      tx_full_reg <= 1'b0;  rx_full_reg <= 1'b0;  flag_reg <= 8'h00;
      irq_request <= 1'b0;
      aw_full_reg <= 1'b0;  aw_addr_reg <= 8'h00;
      w_full_reg <= 1'b0;  w_data_reg <= 8'h00;  w_strb_reg <= 1'b0;
      axi_rsp <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
    end else begin
      hi_reg <= hi_next;  lo_reg <= lo_next;
      c1_reg <= c1_next;  c2_reg <= c2_next;  c3_reg <= c3_next;
      work_hi_reg <= work_hi_next;  baud_active_reg <= baud_active_next;
      tx_buf_reg <= tx_buf_next;  rx_data_reg <= rx_data_next;
      tx_full_reg <= tx_full_next;  rx_full_reg <= rx_full_next;  flag_reg <= flag_next;
      irq_request <= irq_next;
      aw_full_reg <= aw_full_next;  aw_addr_reg <= aw_addr_next;
      w_full_reg <= w_full_next;  w_data_reg <= w_data_next;  w_strb_reg <= w_strb_next;
      axi_rsp <= rsp_next;
    end
  end

  // ************************************************************
  // Transmitter
  // ************************************************************
  always_comb begin
    logic [8:0] d;
    d = tx_buf_reg;
    tx_state_next = tx_state_reg;
    tx_sh_next = tx_sh_reg;
    tx_left_next = tx_left_reg;
    tx_sub_next = tx_sub_reg;
    if (tx_load) begin
      if (c1_reg[UBF_C1_PE]) begin
        if (c1_reg[UBF_C1_NINE]) d[8] = ubf_parity(d, 1'b1, c1_reg[UBF_C1_PT]);
        else d[7] = ubf_parity(d, 1'b0, c1_reg[UBF_C1_PT]);
      end
      tx_sh_next = c1_reg[UBF_C1_NINE] ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
      tx_left_next = c1_reg[UBF_C1_NINE] ? UBF_FRAME_9 : UBF_FRAME_8;
      tx_sub_next = 4'h0;
      tx_state_next = UBF_TX_SHIFT;
    end else if (tx_state_reg == UBF_TX_SHIFT && tick) begin
      tx_sub_next = tx_sub_reg + 4'h1;
      if (tx_sub_reg == UBF_SUB_LAST) begin
        tx_sh_next = {1'b1, tx_sh_reg[10:1]};
        tx_left_next = tx_left_reg - 4'h1;
        if (tx_left_reg == 4'h1) tx_state_next = UBF_TX_IDLE;
      end
    end
    tx_line_next = (tx_state_next == UBF_TX_SHIFT) ? tx_sh_next[0] : UBF_LINE_IDLE;
    // A frame in flight keeps the pin even after the enable drops.
    tx_oe_next = (c2_reg[UBF_C2_TX_ON] || tx_state_next == UBF_TX_SHIFT) &&
                 (!(c1_reg[UBF_C1_LOOP] && c1_reg[UBF_C1_RECEIVER_SOURCE_SELECT]) || c3_reg[UBF_C3_DIR]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_reg <= UBF_TX_IDLE;  tx_sh_reg <= 11'h7ff;
      tx_left_reg <= 4'h0;  tx_sub_reg <= 4'h0;
      tx_line_reg <= UBF_LINE_IDLE;  txd_pin_out <= UBF_LINE_IDLE;  txd_pin_oe <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;  tx_sh_reg <= tx_sh_next;
      tx_left_reg <= tx_left_next;  tx_sub_reg <= tx_sub_next;
      tx_line_reg <= tx_line_next;  txd_pin_out <= tx_line_next;  txd_pin_oe <= tx_oe_next;
    end
  end

  // ************************************************************
  // Receiver and idle detector
  // ************************************************************
  always_comb begin
    rx_state_next = rx_state_reg;  rx_sub_next = rx_sub_reg;
    rx_cnt_next = rx_cnt_reg;  rx_sh_next = rx_sh_reg;
    rx_done = 1'b0;  rx_fe = 1'b0;  rx_pe = 1'b0;  rx_brk = 1'b0;
    rx_word = c1_reg[UBF_C1_NINE] ? rx_sh_reg : {1'b0, rx_sh_reg[8:1]};
    idle_bits_next = idle_bits_reg;  idle_sub_next = idle_sub_reg;
    idle_armed_next = idle_armed_reg;
    rx_prev_next = rx_line;
    rx_edge_hit = c2_reg[UBF_C2_RX_ON] && !frz && rx_prev_reg && !rx_line;
    if (tick) begin
      case (rx_state_reg)
        UBF_RX_IDLE: if (!rx_line) begin
          rx_state_next = UBF_RX_START;
          rx_sub_next = 4'h0;
          idle_armed_next = 1'b1;
        end
        UBF_RX_START: if (rx_sub_reg == UBF_SUB_MID) begin
          rx_state_next = rx_line ? UBF_RX_IDLE : UBF_RX_DATA;
          rx_sub_next = 4'h0;
          rx_cnt_next = 4'h0;
        end else rx_sub_next = rx_sub_reg + 4'h1;
        UBF_RX_DATA: if (rx_sub_reg == UBF_SUB_LAST) begin
          rx_sh_next = {rx_line, rx_sh_reg[8:1]};
          rx_cnt_next = rx_cnt_reg + 4'h1;
          rx_sub_next = 4'h0;
          if (rx_cnt_next == (c1_reg[UBF_C1_NINE] ? UBF_DATA_9 : UBF_DATA_8))
            rx_state_next = UBF_RX_STOP;
        end else rx_sub_next = rx_sub_reg + 4'h1;
        UBF_RX_STOP: if (rx_sub_reg == UBF_SUB_LAST) begin
          rx_done = 1'b1;
          rx_fe = !rx_line;
          rx_brk = !rx_line && rx_word == 9'h000;
          rx_pe = c1_reg[UBF_C1_PE] && (ubf_parity(rx_word, c1_reg[UBF_C1_NINE],
                  c1_reg[UBF_C1_PT]) != (c1_reg[UBF_C1_NINE] ? rx_word[8] : rx_word[7]));
          rx_state_next = UBF_RX_IDLE;
        end else rx_sub_next = rx_sub_reg + 4'h1;
        default: rx_state_next = UBF_RX_IDLE;
      endcase
    end
    if (!c2_reg[UBF_C2_RX_ON]) begin
      rx_state_next = UBF_RX_IDLE;
      rx_done = 1'b0;
      rx_brk = 1'b0;
    end
    if (!rx_line || (c1_reg[UBF_C1_ILT] && rx_state_reg != UBF_RX_IDLE)) begin
      idle_bits_next = 4'h0;
      idle_sub_next = 4'h0;
    end else if (tick) begin
      idle_sub_next = idle_sub_reg + 4'h1;
      if (idle_sub_reg == UBF_SUB_LAST &&
          idle_bits_reg != (c1_reg[UBF_C1_NINE] ? UBF_FRAME_9 : UBF_FRAME_8))
        idle_bits_next = idle_bits_reg + 4'h1;
    end
    rx_idle_hit = c2_reg[UBF_C2_RX_ON] && idle_armed_reg &&
                  idle_bits_reg == (c1_reg[UBF_C1_NINE] ? UBF_FRAME_9 : UBF_FRAME_8);
    if (rx_idle_hit) idle_armed_next = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_reg <= UBF_RX_IDLE;  rx_sub_reg <= 4'h0;
      rx_cnt_reg <= 4'h0;  rx_sh_reg <= 9'h000;
      idle_bits_reg <= 4'h0;  idle_sub_reg <= 4'h0;
      idle_armed_reg <= 1'b0;  rx_prev_reg <= UBF_LINE_IDLE;
    end else begin
      rx_state_reg <= rx_state_next;  rx_sub_reg <= rx_sub_next;
      rx_cnt_reg <= rx_cnt_next;  rx_sh_reg <= rx_sh_next;
      idle_bits_reg <= idle_bits_next;  idle_sub_reg <= idle_sub_next;
      idle_armed_reg <= idle_armed_next;  rx_prev_reg <= rx_prev_next;
    end
  end
endmodule // ubf_uart_cfg_top
`default_nettype wire

// [verification/ubf_cfg_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module ubf_cfg_assertions
  import ubf_pkg::*;
(
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire ubf_axi_req_t axi_req,
  input wire ubf_axi_rsp_t axi_rsp,
  input wire logic         rxd_pin_in,
  input wire logic         txd_pin_in,
  input wire logic         txd_pin_out,
  input wire logic         txd_pin_oe,
  input wire logic         cpu_wait,
  input wire logic         irq_request
);
  // ************************************************************
  // Bus and pin relations
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wr_take;
  logic ar_take;
  logic aw_bad;
  logic ar_bad;
  assign wr_take = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  assign ar_take = axi_req.arvalid && axi_rsp.arready;
  assign aw_bad  = (axi_req.awaddr >= 8'h20) || (axi_req.awaddr[1:0] != 2'h0);
  assign ar_bad  = (axi_req.araddr >= 8'h20) || (axi_req.araddr[1:0] != 2'h0);
  a_write_okay: assert property (
    wr_take && !aw_bad |-> ##[1:2] (axi_rsp.bvalid && axi_rsp.bresp == UBF_RESP_OKAY))
    else $error("mapped write not answered okay");
  a_write_err: assert property (
    wr_take && aw_bad |-> ##[1:2] (axi_rsp.bvalid && axi_rsp.bresp == UBF_RESP_SLVERR))
    else $error("unmapped write not refused");
  a_read_answer: assert property (ar_take |=> axi_rsp.rvalid)
    else $error("read not answered next cycle");
  a_read_err: assert property (
    ar_take && ar_bad |=> axi_rsp.rresp == UBF_RESP_SLVERR && axi_rsp.rdata == 32'h0)
    else $error("unmapped read not refused");
  a_byte_wide: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_b_clear: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
    else $error("write response not released");
  a_ar_block: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read accepted while answer pending");
  a_irq_off: assert property (
    wr_take && axi_req.awaddr == UBF_OFF_BAUD_HI && axi_req.wdata[7:6] == 2'h0
    |-> ##4 !irq_request) else $error("interrupt with both enables clear");
  a_rst_idle: assert property (
    $rose(aresetn) |-> txd_pin_out && !txd_pin_oe && !irq_request)
    else $error("pins not idle after reset");
endmodule // ubf_cfg_assertions

bind ubf_uart_cfg_top ubf_cfg_assertions ubf_cfg_assertions_i (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .rxd_pin_in(rxd_pin_in), .txd_pin_in(txd_pin_in), .txd_pin_out(txd_pin_out),
  .txd_pin_oe(txd_pin_oe), .cpu_wait(cpu_wait), .irq_request(irq_request));
`default_nettype wire

// [verification/ubf_remote_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ubf_remote_model (
  input  wire logic aclk,
  input  wire logic txd_pin_out,
  input  wire logic txd_pin_oe,
  output var  logic rxd_line,
  output var  logic txd_line
);
  // ************************************************************
  // Line model and frame capture
  // ************************************************************
  // pull-up on line
  always_comb txd_line = txd_pin_oe ? txd_pin_out : 1'b1;
  initial rxd_line = 1'b1;
  task automatic catch_frame(input int bit_len, input int n, output logic [10:0] bits,
                             output logic seen);
    int i;
    seen = 1'b0;
    bits = 11'h0;
    for (i = 0; i < 4000 && !seen; i++) begin
      @(negedge aclk);
      seen = !txd_line;
    end
    repeat (bit_len / 2) @(negedge aclk);
    for (i = 0; i < n; i++) begin
      bits[i] = txd_line;
      repeat (bit_len) @(negedge aclk);
    end
  endtask
  // Short low glitch gives an active edge without a valid start bit.
  task automatic pulse_low(input int n);
    @(posedge aclk);
    rxd_line <= 1'b0;
    repeat (n) @(posedge aclk);
    rxd_line <= 1'b1;
  endtask
endmodule // ubf_remote_model
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ubf_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic cpu_wait = 1'b0;
  ubf_axi_req_t req = '0;
  ubf_axi_rsp_t rsp;
  logic rxd, txl, tx_out, tx_oe, irq, prev, seen;
  logic [10:0] bits;
  int fail_count = 0, n_checks = 0, cyc = 0, i, n;
  logic [7:0] tc [4] = '{8'h13, 8'h03, 8'h02, 8'h00};
  logic [7:0] td [4] = '{8'h03, 8'h03, 8'h07, 8'ha5};
  logic [10:0] te [4] = '{11'h606, 11'h306, 11'h30e, 11'h34a};
  always #50 aclk = ~aclk;
  ubf_uart_cfg_top ubf_uart_cfg_top_i (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
    .axi_rsp(rsp), .rxd_pin_in(rxd), .txd_pin_in(txl), .txd_pin_out(tx_out),
    .txd_pin_oe(tx_oe), .cpu_wait(cpu_wait), .irq_request(irq));
  ubf_remote_model ubf_remote_model_i (.aclk(aclk), .txd_pin_out(tx_out),
    .txd_pin_oe(tx_oe), .rxd_line(rxd), .txd_line(txl));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_t, w_t;
    @(posedge aclk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hf;
    req.wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      aw_t = req.awvalid && rsp.awready;
      w_t = req.wvalid && rsp.wready;
      @(posedge aclk);
      if (aw_t) req.awvalid <= 1'b0;
      if (w_t) req.wvalid <= 1'b0;
    end while ((req.awvalid && !aw_t) || (req.wvalid && !w_t));
    do @(negedge aclk); while (rsp.bvalid !== 1'b1);
    chk({30'h0, rsp.bresp}, {30'h0, er});
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
    logic t;
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      t = rsp.arready;
      @(posedge aclk);
    end while (t !== 1'b1);
    req.arvalid <= 1'b0;
    do @(negedge aclk); while (rsp.rvalid !== 1'b1);
    chk(rsp.rdata, {24'h0, exp});
    chk({30'h0, rsp.rresp}, {30'h0, er});
    @(posedge aclk);
  endtask
  task automatic send(input logic [7:0] d, input int bl, input int nb, input logic [10:0] e);
    wr(UBF_OFF_DATA, d, UBF_RESP_OKAY);
    ubf_remote_model_i.catch_frame(bl, nb, bits, seen);
    chk({20'h0, seen, bits}, {20'h0, 1'b1, e});
    chk({31'h0, tx_oe}, 32'h1);
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    req.bready = 1'b1;
    req.rready = 1'b1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(UBF_OFF_BAUD_HI, 8'h00, UBF_RESP_OKAY);
    rd(UBF_OFF_BAUD_LO, UBF_RST_BAUD_LO, UBF_RESP_OKAY);
    wr(UBF_OFF_BAUD_HI, 8'hff, UBF_RESP_OKAY);
    rd(UBF_OFF_BAUD_HI, 8'hdf, UBF_RESP_OKAY);
    for (i = 0; i < 8; i++) begin
      wr(UBF_OFF_CTRL1, 8'h01 << i, UBF_RESP_OKAY);
      rd(UBF_OFF_CTRL1, 8'h01 << i, UBF_RESP_OKAY);
    end
    wr(8'h20, 8'h00, UBF_RESP_SLVERR);
    rd(8'h22, 8'h00, UBF_RESP_SLVERR);
    wr(UBF_OFF_BAUD_HI, 8'h00, UBF_RESP_OKAY);
    wr(UBF_OFF_BAUD_LO, 8'h01, UBF_RESP_OKAY);
    wr(UBF_OFF_CTRL2, 8'h0c, UBF_RESP_OKAY);
    for (i = 0; i < 4; i++) begin
      wr(UBF_OFF_CTRL1, tc[i], UBF_RESP_OKAY);
      send(td[i], 16, tc[i][4] ? 11 : 10, te[i]);
    end
    wr(UBF_OFF_BAUD_HI, 8'h01, UBF_RESP_OKAY);
    send(8'h5a, 16, 10, 11'h2b4);
    wr(UBF_OFF_BAUD_HI, 8'h00, UBF_RESP_OKAY);
    wr(UBF_OFF_BAUD_LO, 8'h02, UBF_RESP_OKAY);
    send(8'h5a, 32, 10, 11'h2b4);
    wr(UBF_OFF_BAUD_HI, 8'h40, UBF_RESP_OKAY);
    ubf_remote_model_i.pulse_low(4);
    for (i = 0; i < 50 && irq !== 1'b1; i++) @(negedge aclk);
    chk({31'h0, irq}, 32'h1);
    wr(UBF_OFF_BAUD_HI, 8'h00, UBF_RESP_OKAY);
    repeat (2) @(negedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(UBF_OFF_BAUD_LO, 8'h00, UBF_RESP_OKAY);
    wr(UBF_OFF_DATA, 8'hff, UBF_RESP_OKAY);
    n = 0;
    prev = txl;
    for (i = 0; i < 400; i++) begin
      @(negedge aclk);
      n += (txl && !prev) ? 1 : 0;
      prev = txl;
    end
    chk(n, 0);
    results();
  end
endmodule // testbench
`default_nettype wire
